/* File: logic/sfphp_pkg.sv */
// Shared constants for the serial flash control block.
// Assumes a 20 MHz core clock and a slower-than-core frame rate.
package sfphp_pkg;
    localparam int CLK_MHZ = 20;
    // Default cycle times in microseconds
    localparam int STATUS_WRITE_TIME_US = 15000;
    localparam int PROGRAM_CYCLE_TIME_US = 5000;
    localparam int SECTOR_ERASE_TIME_US = 3000000;
    localparam int BULK_ERASE_TIME_US = 10000000;
    localparam int POWER_UP_WRITE_DELAY_US = 10000;
    // Instruction codes
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
    localparam logic [7:0] BULK_ERASE_CMD = 8'hC7;
    localparam logic [7:0] DEEP_SLEEP_CMD = 8'hB9;
    localparam logic [7:0] WAKE_SIGNATURE_CMD = 8'hAB;
    // Frame lengths in bytes, and bit counts within a byte
    localparam logic [8:0] ONE_BYTE = 9'h001;
    localparam logic [8:0] SW_BYTES = 9'h002;
    localparam logic [8:0] HDR_BYTES = 9'h004;
    localparam logic [8:0] PROG_MAX_BYTES = 9'h104;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [8:0] BYTE_SAT = 9'h1FF;
    localparam logic [2:0] BIT_ALIGNED = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Status byte layout and reset values
    localparam int SR_LOCK_POS = 7;
    localparam int SR_BP_LSB = 2;
    localparam logic [2:0] PROT_LEVEL_RST = 3'h0;
    localparam logic STATUS_LOCK_RST = 1'b0;
    typedef enum logic [1:0] {
        OP_PROG = 2'h0,
        OP_SECT = 2'h1,
        OP_BULK = 2'h2,
        OP_STAT = 2'h3
    } sfphp_kind_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } sfphp_state_t;
endpackage

/* File: logic/sfphp_top.sv */
// Serial flash operating control: framing, protection, busy timing, pause.
// Assumes an SPI master on sck/cs_n/sdi; array itself lives outside.
`timescale 1ns/1ns
// How it works
// - Program 1..256 bytes inside one page
// - Sector and bulk erase start timed cycles
// - Busy flag high during every internal cycle
// - Select low means active power mode
// - Deselected stays active until cycle ends
// - Sleep command enters deep sleep until wake
// - Deep sleep ignores all but wake
// - Hardware protection freezes non-volatile status bits
// - Protect level decodes to protected sectors
// - Bulk erase only with level zero
// - Writes need clock count multiple of eight
// - Write latch cleared at reset and completion
// - Power-up delay blocks modifying operations
// - Pause keeps bit count, cycles continue
// - Pause starts at hold fall or clock low
// - Pause ends at hold rise or clock low
// - Paused link ignores data and clock
// - Deselect while paused resets the interface
// - Refuse writes while write latch clear
module sfphp_top #(
    parameter int SW_US = sfphp_pkg::STATUS_WRITE_TIME_US,
    parameter int PROG_US = sfphp_pkg::PROGRAM_CYCLE_TIME_US,
    parameter int SECT_US = sfphp_pkg::SECTOR_ERASE_TIME_US,
    parameter int BULK_US = sfphp_pkg::BULK_ERASE_TIME_US,
    parameter int PUW_US = sfphp_pkg::POWER_UP_WRITE_DELAY_US
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic op_start,
    output sfphp_pkg::sfphp_kind_t op_kind,
    output logic [23:0] op_addr,
    output logic [8:0] op_len,
    output logic busy_flag,
    output logic write_latch_flag,
    output logic [2:0] protect_level,
    output logic status_lock_bit,
    output logic hw_protected,
    output logic deep_sleep,
    output logic active_mode,
    output logic paused
);
    import sfphp_pkg::*;

    function automatic logic [31:0] cyc(input int us);
        cyc = 32'(us * CLK_MHZ);
    endfunction

    // Sector covered by a protect level
    function automatic logic prot_hit(input logic [2:0] bp, input logic [2:0] sec);
        prot_hit = bp[2] || (bp == 3'h1 && sec == 3'h7) || (bp == 3'h2 && sec[2:1] == 2'h3)
            || (bp == 3'h3 && sec[2]);
    endfunction

    localparam logic [31:0] SW_CYC = cyc(SW_US);
    localparam logic [31:0] PROG_CYC = cyc(PROG_US);
    localparam logic [31:0] SECT_CYC = cyc(SECT_US);
    localparam logic [31:0] BULK_CYC = cyc(BULK_US);
    localparam logic [31:0] PUW_CYC = cyc(PUW_US);

    // ---- Link domain, clocked by the serial clock ----
    logic first_q;
    logic tgl_q;
    logic [2:0] bcnt_q;
    logic [7:0] sh_q;
    logic [7:0] cmd_q;
    logic [8:0] nby_q;
    logic [23:0] adr_q;

    // Deselect rearms framing; no sck edge is needed to end a frame
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            first_q <= 1'b1;
        end else if (hold_n) begin
            first_q <= 1'b0;
        end
    end

    wire [2:0] bcnt_w = first_q ? 3'h0 : bcnt_q;
    wire [8:0] nby_w = first_q ? 9'h000 : nby_q;
    wire [7:0] byte_w = {sh_q[6:0], sdi};
    wire byte_done = bcnt_w == BIT_LAST;
    wire nby_inc = byte_done && nby_w != BYTE_SAT;

    // Hold low at a rising edge means paused: edge is ignored, count kept
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            tgl_q <= 1'b0;
            bcnt_q <= 3'h0;
            sh_q <= 8'h00;
            cmd_q <= 8'h00;
            nby_q <= 9'h000;
            adr_q <= 24'h000000;
        end else if (hold_n) begin
            tgl_q <= tgl_q ^ first_q;
            bcnt_q <= bcnt_w + 3'h1;
            sh_q <= byte_w;
            nby_q <= nby_w + {8'h00, nby_inc};
            if (byte_done && nby_w == 9'h000) begin
                cmd_q <= byte_w;
            end
            if (byte_done && nby_w != 9'h000 && nby_w < HDR_BYTES) begin
                adr_q <= {adr_q[15:0], byte_w};
            end
        end
    end

    // ---- Core domain ----
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic cs_p_q;
    logic tseen_q;
    logic [31:0] pu_q;
    logic [31:0] tmr_q;
    logic [31:0] tmr_d;
    sfphp_state_t state_q;
    sfphp_state_t state_d;

    // Synchronised pins; link words are read only after deselect, when static
    wire cs_s = s2_q[0];
    wire sck_s = s2_q[1];
    wire hold_s = s2_q[2];
    wire wp_s = s2_q[3];
    wire tgl_s = s2_q[4];
    wire fend = cs_s && !cs_p_q && tgl_s != tseen_q;
    wire pu_done = pu_q == 32'h0;
    wire idle = state_q == ST_IDLE;
    wire aligned = bcnt_q == BIT_ALIGNED;
    wire hw_lock = status_lock_bit && !wp_s;

    // Frame decode; a frame that ended while paused is dropped
    wire take = fend && !paused;
    wire gate = take && idle && aligned && !deep_sleep;
    wire wr_ok = gate && write_latch_flag && pu_done;
    wire [2:0] sec = adr_q[18:16];
    wire [8:0] prog_len = nby_q - HDR_BYTES;
    wire pg_ok = ({1'b0, adr_q[7:0]} + prog_len) <= PAGE_BYTES;
    wire prog_sz = nby_q > HDR_BYTES && nby_q <= PROG_MAX_BYTES;
    wire go_prog = wr_ok && cmd_q == PAGE_PROGRAM_CMD && prog_sz && pg_ok
        && !prot_hit(protect_level, sec);
    wire go_sect = wr_ok && cmd_q == SECTOR_ERASE_CMD && nby_q == HDR_BYTES
        && !prot_hit(protect_level, sec);
    wire go_bulk = wr_ok && cmd_q == BULK_ERASE_CMD && nby_q == ONE_BYTE
        && protect_level == 3'h0;
    wire go_sw = wr_ok && cmd_q == STATUS_WRITE_CMD && nby_q == SW_BYTES && !hw_lock;
    wire go_wen = gate && cmd_q == WRITE_ENABLE_CMD && nby_q == ONE_BYTE;
    wire go_wdis = gate && cmd_q == WRITE_DISABLE_CMD && nby_q == ONE_BYTE;
    wire go_sleep = gate && cmd_q == DEEP_SLEEP_CMD && nby_q == ONE_BYTE;
    wire go_wake = take && deep_sleep && cmd_q == WAKE_SIGNATURE_CMD;
    wire go_any = go_prog || go_sect || go_bulk || go_sw;
    wire done = state_q == ST_BUSY && tmr_q == 32'h1;
    wire [31:0] load = go_prog ? PROG_CYC : go_sect ? SECT_CYC : go_bulk ? BULK_CYC : SW_CYC;
    wire paused_d = cs_s ? 1'b0 : (sck_s ? paused : !hold_s);
    wire wel_d = go_wen || (write_latch_flag && !go_wdis && !done);

    // Busy timer; a late enable framed while busy fails gate and is dropped
    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q;
        case (state_q)
            ST_IDLE: begin
                if (go_any) begin
                    state_d = ST_BUSY;
                    tmr_d = load;
                end
            end
            ST_BUSY: begin
                tmr_d = tmr_q - 32'h1;
                if (done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                tmr_d = 32'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // Idle pin levels and toggle 0, so the first frame is not lost
            s1_q <= 5'h0D;
            s2_q <= 5'h0D;
            cs_p_q <= 1'b1;
            tseen_q <= 1'b0;
            pu_q <= PUW_CYC;
            state_q <= ST_IDLE;
            tmr_q <= 32'h0;
        end else begin
            s1_q <= {tgl_q, wp_n, hold_n, sck, cs_n};
            s2_q <= s1_q;
            cs_p_q <= cs_s;
            tseen_q <= cs_s && !cs_p_q ? tgl_s : tseen_q;
            pu_q <= pu_done ? pu_q : pu_q - 32'h1;
            state_q <= state_d;
            tmr_q <= tmr_d;
        end
    end

    // Output flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_start <= 1'b0;
            op_kind <= OP_PROG;
            op_addr <= 24'h000000;
            op_len <= 9'h000;
            busy_flag <= 1'b0;
            write_latch_flag <= 1'b0;
            protect_level <= PROT_LEVEL_RST;
            status_lock_bit <= STATUS_LOCK_RST;
            hw_protected <= 1'b0;
            deep_sleep <= 1'b0;
            active_mode <= 1'b0;
            paused <= 1'b0;
        end else begin
            op_start <= go_any;
            if (go_any) begin
                op_kind <= go_prog ? OP_PROG : go_sect ? OP_SECT : go_bulk ? OP_BULK : OP_STAT;
                op_addr <= adr_q;
                op_len <= go_prog ? prog_len : 9'h000;
            end
            busy_flag <= state_d == ST_BUSY;
            write_latch_flag <= wel_d;
            if (go_sw) begin
                protect_level <= adr_q[SR_BP_LSB+2:SR_BP_LSB];
                status_lock_bit <= adr_q[SR_LOCK_POS];
            end
            hw_protected <= hw_lock;
            deep_sleep <= go_sleep || (deep_sleep && !go_wake);
            active_mode <= !cs_s || state_q == ST_BUSY;
            paused <= paused_d;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    busy_follows_start_a: assert property (op_start |-> busy_flag [*2])
        else $error("busy not held after start");
    latch_clear_done_a: assert property ($fell(busy_flag) |-> !write_latch_flag)
        else $error("write latch kept after cycle");
    sleep_ignores_a: assert property (deep_sleep && fend && cmd_q != WAKE_SIGNATURE_CMD
        |=> deep_sleep && !op_start)
        else $error("command taken in deep sleep");
    sleep_enter_a: assert property (go_sleep |=> deep_sleep)
        else $error("deep sleep not entered");
    bulk_level_a: assert property (op_start && op_kind == OP_BULK
        |-> $past(protect_level) == 3'h0)
        else $error("bulk erase with protection");
    lock_frozen_a: assert property (hw_protected
        |-> $stable(protect_level) && $stable(status_lock_bit))
        else $error("status changed under hardware protection");
    active_stays_a: assert property (busy_flag |=> active_mode)
        else $error("standby during cycle");
    unaligned_drop_a: assert property (fend && !aligned |=> !op_start)
        else $error("unaligned frame executed");
    latch_refuse_a: assert property (fend && !write_latch_flag |=> !op_start)
        else $error("write without latch");
    powerup_block_a: assert property (!pu_done |=> !op_start)
        else $error("write during power-up delay");
    pause_enter_a: assert property (!cs_s && !sck_s && !hold_s |=> paused)
        else $error("pause not entered");
    pause_leave_a: assert property (!sck_s && hold_s |=> !paused)
        else $error("pause not left");
    sector_guard_a: assert property (op_start && op_kind != OP_STAT && op_kind != OP_BULK
        |-> !prot_hit($past(protect_level), op_addr[18:16]))
        else $error("protected sector written");

    // Deep sleep, cycle start and end checks
    wake_leave_a: assert property (go_wake |=> !deep_sleep)
        else $error("deep sleep not left on wake");
    sleep_stays_a: assert property (deep_sleep && !go_wake |=> deep_sleep)
        else $error("deep sleep left without wake");
    done_clears_a: assert property (done |=> !busy_flag && !write_latch_flag)
        else $error("cycle end left busy or latch set");
    start_latch_a: assert property (op_start |-> $past(write_latch_flag))
        else $error("cycle started without latch");
    start_power_a: assert property (op_start |-> $past(pu_done))
        else $error("cycle started in power-up delay");
    prog_page_a: assert property (op_start && op_kind == OP_PROG
        |-> op_len != 9'h000 && ({1'b0, op_addr[7:0]} + op_len) <= PAGE_BYTES)
        else $error("program crosses page end");

    // Mode and pause checks
    select_active_a: assert property (!cs_s |=> active_mode)
        else $error("selected but not active");
    standby_idle_a: assert property (cs_s && idle |=> !active_mode)
        else $error("standby not entered when idle");
    deselect_unpause_a: assert property (cs_s |=> !paused)
        else $error("pause kept after deselect");
    pause_keep_a: assert property (!cs_s && sck_s |=> $stable(paused))
        else $error("pause changed while clock high");
endmodule

/* File: tb/serial_flash_protect_hold_power_test.sv */
// Self-checking bench for the serial flash control block.
// Assumes the master model drives the link; cycle times shortened.
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module serial_flash_protect_hold_power_test;
    import sfphp_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic wp_n = 1'b1;
    logic sck, cs_n, sdi, hold_n, op_start, busy_flag, write_latch_flag;
    logic status_lock_bit, hw_protected, deep_sleep, active_mode, paused;
    sfphp_kind_t op_kind;
    logic [23:0] op_addr;
    logic [8:0] op_len;
    logic [2:0] protect_level;
    int miscompares = 0;
    int samples_checked = 0;
    int starts = 0;
    int run = 0;
    int last_len = 0;
    int pseen = 0;
    // Shortened cycle times in microseconds
    localparam int SW_T = 1;
    localparam int PROG_T = 2;
    localparam int SECT_T = 3;
    localparam int BULK_T = 4;
    localparam int PUW_T = 5;
    always #25 core_clk = ~core_clk;
    sfphp_spi_master i_mst (.core_clk, .sck, .cs_n, .sdi, .hold_n);
    sfphp_top #(.SW_US(SW_T), .PROG_US(PROG_T), .SECT_US(SECT_T), .BULK_US(BULK_T),
        .PUW_US(PUW_T)) i_dut (
        .core_clk, .arst_n, .sck, .cs_n, .sdi, .hold_n, .wp_n, .op_start, .op_kind,
        .op_addr, .op_len, .busy_flag, .write_latch_flag, .protect_level,
        .status_lock_bit, .hw_protected, .deep_sleep, .active_mode, .paused);
    // Counts starts, pause cycles and the length of each busy spell
    always @(posedge core_clk) begin
        if (op_start === 1'b1) starts++;
        if (paused === 1'b1) pseen++;
        if (busy_flag === 1'b1) run++;
        else if (run != 0) begin
            last_len = run;
            run = 0;
        end
    end
    task automatic finish_test();
        $display("Checked %0d, miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Frame, then compare whether a cycle was launched
    task automatic op(input logic [7:0] q[$], input logic e, input int xb = 0, input int pm = 0);
        int s0;
        s0 = starts;
        i_mst.frame(q, xb, pm);
        repeat (8) @(posedge core_clk);
        `CHK(logic'(starts != s0), e)
    endtask
    task automatic idle();
        int k;
        for (k = 0; k < 400 && busy_flag !== 1'b0; k++) @(posedge core_clk);
        if (k == 400) begin
            miscompares++;
            finish_test();
        end
        repeat (2) @(posedge core_clk);
    endtask
    task automatic wen();
        i_mst.frame({WRITE_ENABLE_CMD}, 0, 0);
    endtask
    // Protected-area decode
    function automatic logic prot(input logic [2:0] lv, input logic [2:0] s);
        return lv[2] | (lv == 3'h1 && s == 3'h7) | (lv == 3'h2 && s[2:1] == 2'h3)
            | (lv == 3'h3 && s[2]);
    endfunction
    initial begin
        int junk;
        int len;
        logic [2:0] sec;
        logic [7:0] q[$];
        logic [23:0] adr;
        junk = $urandom(32'hF766);
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK(write_latch_flag, 1'b0)
        wen();
        op({SECTOR_ERASE_CMD, 8'h00, 8'h00, 8'h00}, 1'b0);
        repeat (PUW_T * CLK_MHZ) @(posedge core_clk);
        op({SECTOR_ERASE_CMD, 8'h00, 8'h00, 8'h00}, 1'b0, 1);
        op({WRITE_DISABLE_CMD}, 1'b0);
        `CHK(write_latch_flag, 1'b0)
        op({SECTOR_ERASE_CMD, 8'h00, 8'h00, 8'h00}, 1'b0);
        $display("Guard test done");
        for (int lv = 0; lv < 8; lv++) begin
            sec = 3'($urandom_range(7));
            wen();
            op({STATUS_WRITE_CMD, 8'(lv << 2)}, 1'b1);
            idle();
            `CHK(last_len, SW_T * CLK_MHZ)
            `CHK(protect_level, 3'(lv))
            wen();
            op({SECTOR_ERASE_CMD, 8'(sec), 8'($urandom), 8'h00}, ~prot(3'(lv), sec));
            `CHK(active_mode, ~prot(3'(lv), sec))
            idle();
            `CHK(write_latch_flag, prot(3'(lv), sec))
            if (!prot(3'(lv), sec)) `CHK(last_len, SECT_T * CLK_MHZ)
            wen();
            op({BULK_ERASE_CMD}, lv == 0);
            idle();
            if (lv == 0) `CHK(last_len, BULK_T * CLK_MHZ)
        end
        $display("Protection test done");
        wen();
        op({STATUS_WRITE_CMD, 8'h00}, 1'b1);
        idle();
        len = $urandom_range(256, 1);
        q = {PAGE_PROGRAM_CMD, 8'h01, 8'h02, 8'($urandom_range(256 - len))};
        repeat (len) q.push_back(8'($urandom));
        wen();
        op(q, 1'b1);
        adr = {8'h01, 8'h02, q[3]};
        `CHK(op_len, 9'(len))
        `CHK(op_kind, OP_PROG)
        `CHK(op_addr, adr)
        idle();
        `CHK(last_len, PROG_T * CLK_MHZ)
        q[3] = 8'hFF;
        q.push_back(8'h00);
        wen();
        op(q, 1'b0);
        op({STATUS_WRITE_CMD, 8'h80}, 1'b1);
        idle();
        `CHK(status_lock_bit, 1'b1)
        wp_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK(hw_protected, 1'b1)
        wen();
        op({STATUS_WRITE_CMD, 8'h00}, 1'b0);
        wp_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        op({STATUS_WRITE_CMD, 8'h00}, 1'b1);
        idle();
        $display("Program and lock test done");
        op({DEEP_SLEEP_CMD}, 1'b0);
        `CHK(deep_sleep, 1'b1)
        wen();
        `CHK(write_latch_flag, 1'b0)
        op({WAKE_SIGNATURE_CMD}, 1'b0);
        `CHK(deep_sleep, 1'b0)
        wen();
        op({SECTOR_ERASE_CMD, 8'h00, 8'h00, 8'h00}, 1'b1, 0, 1);
        `CHK(logic'(pseen > 0), 1'b1)
        idle();
        // A whole enable byte clocked before the pause must still be dropped
        op({WRITE_ENABLE_CMD, 8'h00}, 1'b0, 0, 2);
        `CHK(write_latch_flag, 1'b0)
        `CHK(paused, 1'b0)
        $display("Sleep and pause test done");
        finish_test();
    end
endmodule

/* File: tb/sfphp_spi_master.sv */
// SPI master model for the flash control link pins.
// Assumes the bench calls frame(); sck idles low outside frames.
`timescale 1ns/1ns
module sfphp_spi_master (
    input wire logic core_clk,
    output logic sck,
    output logic cs_n,
    output logic sdi,
    output logic hold_n
);
    // Idle levels
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        hold_n = 1'b1;
    end
    // One frame, MSB first; pm 1 pauses mid-frame, pm 2 deselects in pause
    task automatic frame(input logic [7:0] q[$], input int xb, input int pm);
        int n;
        n = q.size() * 8 + xb;
        @(posedge core_clk);
        #1 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi = (i < q.size() * 8) ? q[i / 8][7 - i % 8] : ~sdi;
            if (pm != 0 && i == 8) begin
                hold_n = 1'b0;
                // Stray clocks in pause must be ignored
                repeat (3) begin
                    #30 sck = 1'b1;
                    #30 sck = 1'b0;
                end
                #100;
                if (pm == 2) begin
                    cs_n = 1'b1;
                    #100 hold_n = 1'b1;
                    break;
                end
                hold_n = 1'b1;
            end
            #3 sck = 1'b1;
            #3 sck = 1'b0;
        end
        #10 cs_n = 1'b1;
        sdi = ~sdi; // Released line keeps no stale value
        repeat (6) @(posedge core_clk);
    endtask
endmodule
